// [rtl/fifo_serial_pkg.sv]
package fifo_serial_pkg;
	// ------------------------------------------------------------
	// sizes and field layout
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_PTR_W = 4;
	localparam int DATA_W = 8;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
	localparam logic [4:0] TRIG_LEVEL_1 = 5'h01;
	localparam logic [4:0] TRIG_LEVEL_4 = 5'h04;
	localparam logic [4:0] TRIG_LEVEL_8 = 5'h08;
	localparam logic [4:0] TRIG_LEVEL_14 = 5'h0e;
	// timeout span in bit times: four characters of ten bits
	localparam int TIMEOUT_BITS = 40;
	// ------------------------------------------------------------
	// baud source prescalers
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_LINK = 2'h0;
	localparam logic [1:0] SRC_SYSTEM = 2'h1;
	localparam int LINK_PRESCALE = 18;
	localparam int SYSTEM_PRESCALE = 11;
	localparam logic [15:0] DIVISOR_RESET = 16'h000c;
	// ------------------------------------------------------------
	// interrupt source codes
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_MODEM = 3'h0;
	localparam logic [2:0] SRC_TX_EMPTY = 3'h1;
	localparam logic [2:0] SRC_RX_READY = 3'h2;
	localparam logic [2:0] SRC_LINE_STATUS = 3'h3;
	localparam logic [2:0] SRC_CHAR_TIMEOUT = 3'h6;
	localparam logic [7:0] ID_RESET = 8'h01;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b011,
		ST_PARITY = 3'b010,
		ST_STOP = 3'b110
	} line_state_type;
endpackage : fifo_serial_pkg

// [rtl/fifo_async_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE_01) separate sixteen-entry transmit and receive buffers
// (RULE_02) buffers accept and deliver characters while shifting goes on
// (RULE_03) bit rate is source clock over sixteen times the divisor
// (RULE_04) divisor joins high byte and low byte registers
// (RULE_05) source select 00 link clock over 18, 01 system clock over 11
// (RULE_06) frame: low start, data lsb first, optional parity, high stop
// (RULE_07) line idles high; a low level starts reception
// (RULE_08) transmitter and receiver run independently, full duplex
// (RULE_09) eight data bits, parity on or off, one or two stops
// (RULE_10) timeout when data waits and buffer untouched four characters
// (RULE_11) receive ready when fill reaches programmed level, fourteen included
// (RULE_12) source code 0 modem, 1 tx empty, 2 rx ready, 3 line, 6 timeout
// (RULE_13) internal loopback that software can switch off
// (RULE_14) modem status may be left unused
// (RULE_15) either host or processor side may operate the port
// (RULE_16) buffers enabled by software; disabled means one-character holding
// (RULE_17) identification: pending flag, buffer enable state, source code
// (RULE_18) receiver samples mid-bit and rechecks start bit
module fifo_async_serial_port #(
	parameter int DEPTH = fifo_serial_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_tick,
	input wire logic [7:0] divisor_high_byte,
	input wire logic [7:0] divisor_low_byte,
	input wire logic [1:0] baud_source_select,
	input wire logic parity_enable,
	input wire logic parity_odd,
	input wire logic two_stop,
	input wire logic tx_buffer_enable,
	input wire logic rx_buffer_enable,
	input wire logic [1:0] rx_trigger_select,
	input wire logic loopback,
	input wire logic modem_change,
	input wire logic [3:0] interrupt_enable,
	input wire logic host_select,
	input wire logic host_tx_write,
	input wire logic [7:0] host_tx_data,
	input wire logic host_rx_read,
	input wire logic cpu_tx_write,
	input wire logic [7:0] cpu_tx_data,
	input wire logic cpu_rx_read,
	input wire logic id_read,
	input wire logic serial_in,
	output logic serial_out,
	output logic [7:0] rx_data,
	output logic rx_data_valid,
	output logic tx_full,
	output logic rx_error,
	output logic [7:0] interrupt_identification,
	output logic interrupt_request
);
	// ----------------------------------------------------------
	// owner mux and pin synchroniser
	// ----------------------------------------------------------
	logic tx_write, rx_read;
	logic [7:0] tx_wdata;
	assign tx_write = host_select ? host_tx_write : cpu_tx_write; // RULE_15
	assign tx_wdata = host_select ? host_tx_data : cpu_tx_data; // RULE_15
	assign rx_read = host_select ? host_rx_read : cpu_rx_read; // RULE_15
	logic [1:0] pin_sync_reg, tick_sync_reg;
	logic tick_prev_reg;
	// two flops before any logic reads the pin or link tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_sync_reg <= 2'h3;
			tick_sync_reg <= 2'h0;
			tick_prev_reg <= 1'b0;
		end
		else
		begin
			pin_sync_reg <= {pin_sync_reg[0], serial_in};
			tick_sync_reg <= {tick_sync_reg[0], link_tick};
			tick_prev_reg <= tick_sync_reg[1];
		end
	end
	// ----------------------------------------------------------
	// baud generator: prescaler then divisor gives x16 tick
	// ----------------------------------------------------------
	logic [4:0] pre_reg;
	logic [15:0] div_reg;
	logic pre_tick, os_tick, src_edge;
	logic [15:0] divisor;
	assign divisor = {divisor_high_byte, divisor_low_byte}; // RULE_04
	assign src_edge = (baud_source_select == fifo_serial_pkg::SRC_LINK) ?
		(tick_sync_reg[1] & ~tick_prev_reg) : 1'b1; // RULE_05
	assign pre_tick = src_edge && (pre_reg == ((baud_source_select == fifo_serial_pkg::SRC_LINK) ?
		5'(fifo_serial_pkg::LINK_PRESCALE - 1) : 5'(fifo_serial_pkg::SYSTEM_PRESCALE - 1)));
	assign os_tick = pre_tick && (div_reg <= 16'h0001); // RULE_03
	// prescaler and divisor counters
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= 5'h00;
			div_reg <= 16'h0000;
		end
		else
		begin
			if (pre_tick)
				pre_reg <= 5'h00;
			else if (src_edge)
				pre_reg <= pre_reg + 5'h01;
			if (os_tick)
				div_reg <= divisor; // RULE_03
			else if (pre_tick)
				div_reg <= div_reg - 16'h0001;
		end
	end
	// ----------------------------------------------------------
	// buffers: one array each, depth forced to 1 when disabled
	// ----------------------------------------------------------
	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic [3:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [4:0] tx_cnt_reg, rx_cnt_reg;
	logic tx_pop, rx_push, rx_pop, tx_push, rx_push_ok;
	logic [4:0] tx_cap, rx_cap;
	logic [7:0] rx_shift_reg;
	assign tx_cap = tx_buffer_enable ? 5'(DEPTH) : 5'h01; // RULE_16
	assign rx_cap = rx_buffer_enable ? 5'(DEPTH) : 5'h01; // RULE_16
	assign tx_push = tx_write && (tx_cnt_reg < tx_cap); // RULE_02
	assign rx_pop = rx_read && (rx_cnt_reg != 5'h00); // RULE_02
	assign rx_push_ok = rx_push && (rx_cnt_reg < rx_cap);
	// transmit and receive buffer storage and pointers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_wp_reg <= 4'h0;
			tx_rp_reg <= 4'h0;
			rx_wp_reg <= 4'h0;
			rx_rp_reg <= 4'h0;
			tx_cnt_reg <= 5'h00;
			rx_cnt_reg <= 5'h00;
		end
		else
		begin
			if (tx_push)
			begin
				tx_mem[tx_wp_reg] <= tx_wdata; // RULE_01
				tx_wp_reg <= tx_wp_reg + 4'h1;
			end
			if (tx_pop)
				tx_rp_reg <= tx_rp_reg + 4'h1;
			tx_cnt_reg <= tx_cnt_reg + 5'(tx_push) - 5'(tx_pop);
			if (rx_push_ok)
			begin
				rx_mem[rx_wp_reg] <= rx_shift_reg; // RULE_01
				rx_wp_reg <= rx_wp_reg + 4'h1;
			end
			if (rx_pop)
				rx_rp_reg <= rx_rp_reg + 4'h1;
			rx_cnt_reg <= rx_cnt_reg + 5'(rx_push_ok) - 5'(rx_pop);
		end
	end
	// ----------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------
	fifo_serial_pkg::line_state_type tx_state_reg;
	logic [3:0] tx_os_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_par_reg, tx_stop2_reg, tx_line;
	assign tx_pop = (tx_state_reg == fifo_serial_pkg::ST_IDLE) && (tx_cnt_reg != 5'h00) && os_tick;
	// independent transmit sequencer, one bit per 16 ticks
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state_reg <= fifo_serial_pkg::ST_IDLE;
			tx_os_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
			tx_stop2_reg <= 1'b0;
			tx_line <= 1'b1;
		end
		else if (os_tick) // RULE_08
		begin
			tx_os_reg <= tx_os_reg + 4'h1;
			unique case (tx_state_reg)
				fifo_serial_pkg::ST_IDLE:
				begin
					tx_line <= 1'b1; // RULE_07
					tx_os_reg <= 4'h0;
					if (tx_cnt_reg != 5'h00)
					begin
						tx_shift_reg <= tx_mem[tx_rp_reg];
						tx_par_reg <= parity_odd;
						tx_state_reg <= fifo_serial_pkg::ST_START;
						tx_line <= 1'b0; // RULE_06
					end
				end
				fifo_serial_pkg::ST_START:
					if (tx_os_reg == fifo_serial_pkg::OVERSAMPLE_LAST)
					begin
						tx_line <= tx_shift_reg[0]; // RULE_06
						tx_bit_reg <= 3'h0;
						tx_state_reg <= fifo_serial_pkg::ST_DATA;
					end
				fifo_serial_pkg::ST_DATA:
					if (tx_os_reg == fifo_serial_pkg::OVERSAMPLE_LAST)
					begin
						tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == 3'h7)
						begin
							tx_state_reg <= parity_enable ? fifo_serial_pkg::ST_PARITY :
								fifo_serial_pkg::ST_STOP; // RULE_09
							tx_line <= parity_enable ? (tx_par_reg ^ tx_shift_reg[0]) : 1'b1;
							tx_stop2_reg <= two_stop; // RULE_09
						end
						else
							tx_line <= tx_shift_reg[1];
					end
				fifo_serial_pkg::ST_PARITY:
					if (tx_os_reg == fifo_serial_pkg::OVERSAMPLE_LAST)
					begin
						tx_line <= 1'b1;
						tx_state_reg <= fifo_serial_pkg::ST_STOP;
					end
				fifo_serial_pkg::ST_STOP:
					if (tx_os_reg == fifo_serial_pkg::OVERSAMPLE_LAST)
					begin
						tx_stop2_reg <= 1'b0;
						if (!tx_stop2_reg)
							tx_state_reg <= fifo_serial_pkg::ST_IDLE;
					end
				default:
					tx_state_reg <= fifo_serial_pkg::ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------
	// receiver with mid-bit sampling
	// ----------------------------------------------------------
	fifo_serial_pkg::line_state_type rx_state_reg;
	logic [3:0] rx_os_reg;
	logic [2:0] rx_bit_reg;
	logic rx_par_reg, rx_in, rx_err_reg, rx_mid;
	assign rx_in = loopback ? tx_line : pin_sync_reg[1]; // RULE_13
	assign rx_mid = os_tick && (rx_os_reg == fifo_serial_pkg::OVERSAMPLE_MID);
	assign rx_push = rx_mid && (rx_state_reg == fifo_serial_pkg::ST_STOP) && rx_in;
	// receive sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state_reg <= fifo_serial_pkg::ST_IDLE;
			rx_os_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_reg <= 1'b0;
			rx_err_reg <= 1'b0;
		end
		else
		begin
			rx_err_reg <= 1'b0;
			if (os_tick)
			begin
				rx_os_reg <= rx_os_reg + 4'h1;
				unique case (rx_state_reg)
					fifo_serial_pkg::ST_IDLE:
					begin
						rx_os_reg <= 4'h0;
						if (!rx_in)
							rx_state_reg <= fifo_serial_pkg::ST_START; // RULE_07
					end
					fifo_serial_pkg::ST_START:
						if (rx_mid)
						begin
							rx_os_reg <= 4'h8;
							rx_bit_reg <= 3'h0;
							rx_par_reg <= parity_odd;
							rx_state_reg <= rx_in ? fifo_serial_pkg::ST_IDLE :
								fifo_serial_pkg::ST_DATA; // RULE_18
						end
					fifo_serial_pkg::ST_DATA:
						if (rx_mid)
						begin
							rx_shift_reg <= {rx_in, rx_shift_reg[7:1]}; // RULE_06
							rx_par_reg <= rx_par_reg ^ rx_in;
							rx_bit_reg <= rx_bit_reg + 3'h1;
							if (rx_bit_reg == 3'h7)
								rx_state_reg <= parity_enable ? fifo_serial_pkg::ST_PARITY :
									fifo_serial_pkg::ST_STOP; // RULE_09
						end
					fifo_serial_pkg::ST_PARITY:
						if (rx_mid)
						begin
							rx_err_reg <= rx_par_reg ^ rx_in;
							rx_state_reg <= fifo_serial_pkg::ST_STOP;
						end
					fifo_serial_pkg::ST_STOP:
						if (rx_mid)
						begin
							rx_err_reg <= !rx_in || (rx_cnt_reg >= rx_cap);
							rx_state_reg <= fifo_serial_pkg::ST_IDLE;
						end
					default:
						rx_state_reg <= fifo_serial_pkg::ST_IDLE;
				endcase
			end
		end
	end
	// ----------------------------------------------------------
	// timeout, line status, identification
	// ----------------------------------------------------------
	logic [5:0] to_bits_reg;
	logic [3:0] to_os_reg;
	logic timeout_reg, line_stat_reg, modem_reg;
	logic [4:0] trig;
	always_comb
	begin
		unique case (rx_trigger_select)
			2'h0: trig = fifo_serial_pkg::TRIG_LEVEL_1;
			2'h1: trig = fifo_serial_pkg::TRIG_LEVEL_4;
			2'h2: trig = fifo_serial_pkg::TRIG_LEVEL_8;
			2'h3: trig = fifo_serial_pkg::TRIG_LEVEL_14; // RULE_11
		endcase
	end
	// idle-buffer timer measured in bit times
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			to_bits_reg <= 6'h00;
			to_os_reg <= 4'h0;
			timeout_reg <= 1'b0;
		end
		else if (rx_push_ok || rx_pop || rx_cnt_reg == 5'h00)
		begin
			to_bits_reg <= 6'h00; // RULE_10
			to_os_reg <= 4'h0;
			timeout_reg <= 1'b0;
		end
		else if (os_tick)
		begin
			to_os_reg <= to_os_reg + 4'h1;
			if (to_os_reg == fifo_serial_pkg::OVERSAMPLE_LAST)
			begin
				if (to_bits_reg == 6'(fifo_serial_pkg::TIMEOUT_BITS - 1))
					timeout_reg <= 1'b1; // RULE_10
				else
					to_bits_reg <= to_bits_reg + 6'h01;
			end
		end
	end
	// sticky line-status and modem flags; event wins over read clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_stat_reg <= 1'b0;
			modem_reg <= 1'b0;
		end
		else
		begin
			line_stat_reg <= rx_err_reg || (line_stat_reg && !id_read);
			modem_reg <= modem_change || (modem_reg && !id_read); // RULE_14
		end
	end
	logic [2:0] code_next;
	logic pend_next;
	// priority: line status, rx ready/timeout, tx empty, modem
	always_comb
	begin
		pend_next = 1'b1;
		code_next = fifo_serial_pkg::SRC_MODEM;
		if (line_stat_reg && interrupt_enable[2])
			code_next = fifo_serial_pkg::SRC_LINE_STATUS; // RULE_12
		else if (rx_cnt_reg >= trig && interrupt_enable[0])
			code_next = fifo_serial_pkg::SRC_RX_READY; // RULE_11
		else if (timeout_reg && interrupt_enable[0])
			code_next = fifo_serial_pkg::SRC_CHAR_TIMEOUT; // RULE_12
		else if (tx_cnt_reg == 5'h00 && interrupt_enable[1])
			code_next = fifo_serial_pkg::SRC_TX_EMPTY;
		else if (!(modem_reg && interrupt_enable[3]))
			pend_next = 1'b0;
	end
	// registered outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			interrupt_identification <= fifo_serial_pkg::ID_RESET;
			interrupt_request <= 1'b0;
			serial_out <= 1'b1;
			rx_data <= 8'h00;
			rx_data_valid <= 1'b0;
			tx_full <= 1'b0;
			rx_error <= 1'b0;
		end
		else
		begin
			// pending flag is active low in bit 0
			interrupt_identification <= {tx_buffer_enable, rx_buffer_enable, 2'h0,
				code_next, !pend_next}; // RULE_17
			interrupt_request <= pend_next;
			serial_out <= loopback ? 1'b1 : tx_line; // RULE_13
			rx_data <= rx_mem[rx_rp_reg];
			rx_data_valid <= (rx_cnt_reg != 5'h00);
			tx_full <= (tx_cnt_reg + 5'(tx_push) >= tx_cap);
			rx_error <= line_stat_reg;
		end
	end
	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	property p_tx_idle_high;
		@(posedge clk) disable iff (!rst_n)
		(tx_state_reg == fifo_serial_pkg::ST_IDLE && !tx_pop) |=> tx_line;
	endproperty
	a_tx_idle_high: assert property (p_tx_idle_high) else $error("line not idle high"); // RULE_07
	property p_start_low;
		@(posedge clk) disable iff (!rst_n)
		tx_pop |=> !tx_line && tx_state_reg == fifo_serial_pkg::ST_START;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low"); // RULE_06
	property p_fifo_bound;
		@(posedge clk) disable iff (!rst_n)
		tx_cnt_reg <= 5'(DEPTH) && rx_cnt_reg <= 5'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("buffer overfilled"); // RULE_01
	property p_disabled_one;
		@(posedge clk) disable iff (!rst_n)
		!tx_buffer_enable && tx_cnt_reg != 5'h00 |-> !tx_push;
	endproperty
	a_disabled_one: assert property (p_disabled_one) else $error("unbuffered took two"); // RULE_16
	logic [3:0] os_gap_reg;
	// cycles since the last oversample tick, saturating
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			os_gap_reg <= 4'h0;
		else if (os_tick)
			os_gap_reg <= 4'h0;
		else if (os_gap_reg != 4'hf)
			os_gap_reg <= os_gap_reg + 4'h1;
	end
	property p_os_period;
		@(posedge clk) disable iff (!rst_n)
		os_tick && baud_source_select == fifo_serial_pkg::SRC_SYSTEM && divisor == 16'h0001
			|-> os_gap_reg >= 4'(fifo_serial_pkg::SYSTEM_PRESCALE - 1);
	endproperty
	a_os_period: assert property (p_os_period) else $error("baud tick too early"); // RULE_05
	property p_timeout_clear;
		@(posedge clk) disable iff (!rst_n)
		rx_pop |=> !timeout_reg;
	endproperty
	a_timeout_clear: assert property (p_timeout_clear) else $error("timeout kept"); // RULE_10
	property p_id_pending;
		@(posedge clk) disable iff (!rst_n)
		interrupt_request |-> !interrupt_identification[0];
	endproperty
	a_id_pending: assert property (p_id_pending) else $error("pending flag wrong"); // RULE_17
	property p_line_priority;
		@(posedge clk) disable iff (!rst_n)
		line_stat_reg && interrupt_enable[2] |=>
			interrupt_identification[3:1] == fifo_serial_pkg::SRC_LINE_STATUS;
	endproperty
	a_line_priority: assert property (p_line_priority) else $error("priority wrong"); // RULE_12
endmodule : fifo_async_serial_port
`default_nettype wire

// [verif/uart_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side serial device model
// ----------------------------------------
module uart_partner (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	int bit_cycles = 176;
	logic par_en = 1'b0;
	logic par_odd = 1'b0;
	logic two_stop = 1'b0;
	logic [7:0] got_q[$];
	int bad_frames = 0;

	// line rests at mark level between frames
	initial line_out = 1'b1;

	// receiver: start edge, then mid-bit samples
	always
	begin : rx_proc
		logic [7:0] b;
		@(negedge line_in);
		repeat (bit_cycles / 2) @(posedge clk);
		if (line_in === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (bit_cycles) @(posedge clk);
				b[i] = line_in;
			end
			if (par_en)
			begin
				repeat (bit_cycles) @(posedge clk);
				if (line_in !== (^b ^ par_odd))
					bad_frames++;
			end
			repeat (bit_cycles) @(posedge clk);
			if (line_in !== 1'b1)
				bad_frames++;
			got_q.push_back(b);
		end
	end

	// one bit time on the line, changed just after an edge
	task automatic hold_bit(input logic v);
		line_out <= v;
		repeat (bit_cycles) @(posedge clk);
	endtask : hold_bit

	// whole frame; bad_par flips the parity bit
	task automatic send_byte(input logic [7:0] b, input logic bad_par);
		@(posedge clk);
		hold_bit(1'b0);
		for (int i = 0; i < 8; i++)
			hold_bit(b[i]);
		if (par_en)
			hold_bit(^b ^ par_odd ^ bad_par);
		hold_bit(1'b1);
		if (two_stop)
			hold_bit(1'b1);
	endtask : send_byte
endmodule : uart_partner
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic link_tick = 1'b0;
	logic [7:0] divisor_high_byte = 8'h00;
	logic [7:0] divisor_low_byte = 8'h01;
	logic [1:0] baud_source_select = 2'h1;
	logic parity_enable = 1'b0, parity_odd = 1'b0, two_stop = 1'b0;
	logic tx_buffer_enable = 1'b1, rx_buffer_enable = 1'b1;
	logic [1:0] rx_trigger_select = 2'h3;
	logic loopback = 1'b0, modem_change = 1'b0, host_select = 1'b0, id_read = 1'b0;
	logic [3:0] interrupt_enable = 4'h1;
	logic host_tx_write = 1'b0, host_rx_read = 1'b0, cpu_tx_write = 1'b0, cpu_rx_read = 1'b0;
	logic [7:0] host_tx_data = 8'h00, cpu_tx_data = 8'h00;
	logic serial_in, serial_out, rx_data_valid, tx_full, rx_error, interrupt_request;
	logic [7:0] rx_data, interrupt_identification;
	int seed = 32'h4f6b;
	int fails = 0, n_tests = 0, cycles = 0;

	fifo_async_serial_port dut (
		.clk, .rst_n, .link_tick, .divisor_high_byte, .divisor_low_byte,
		.baud_source_select, .parity_enable, .parity_odd, .two_stop,
		.tx_buffer_enable, .rx_buffer_enable, .rx_trigger_select, .loopback,
		.modem_change, .interrupt_enable, .host_select, .host_tx_write,
		.host_tx_data, .host_rx_read, .cpu_tx_write, .cpu_tx_data, .cpu_rx_read,
		.id_read, .serial_in, .serial_out, .rx_data, .rx_data_valid, .tx_full,
		.rx_error, .interrupt_identification, .interrupt_request
	);
	uart_partner p (
		.clk(clk),
		.line_in(serial_out),
		.line_out(serial_in)
	);

	// ----------------------------------------
	// clocks and run-length guard
	// ----------------------------------------
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// link clock rises every second system cycle
	always @(negedge clk)
		link_tick <= ~link_tick;
	// cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// expectations and checks
	// ----------------------------------------
	function automatic int bit_len(input logic [15:0] div, input logic [1:0] src);
		int pre;
		pre = (src == fifo_serial_pkg::SRC_LINK) ? 2 * fifo_serial_pkg::LINK_PRESCALE
			: fifo_serial_pkg::SYSTEM_PRESCALE;
		return fifo_serial_pkg::OVERSAMPLE * int'(div) * pre;
	endfunction : bit_len
	function automatic logic [7:0] exp_id(input logic [2:0] code, input logic pend);
		return {tx_buffer_enable, rx_buffer_enable, 2'b00, code, ~pend};
	endfunction : exp_id
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_byte(what, {7'h00, exp}, {7'h00, got});
	endtask : chk_bit
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk
	task automatic push(input logic [7:0] b);
		@(negedge clk);
		host_tx_write = host_select;
		cpu_tx_write = ~host_select;
		host_tx_data = b;
		cpu_tx_data = b;
		@(negedge clk);
		host_tx_write = 1'b0;
		cpu_tx_write = 1'b0;
		@(negedge clk); // let the full flag settle
	endtask : push
	task automatic pop(output logic [7:0] b);
		int k = 0;
		@(negedge clk);
		while (rx_data_valid !== 1'b1 && k < 30000)
		begin
			@(negedge clk);
			k++;
		end
		b = rx_data;
		host_rx_read = host_select;
		cpu_rx_read = ~host_select;
		@(negedge clk);
		host_rx_read = 1'b0;
		cpu_rx_read = 1'b0;
		wait_clk(3); // stale window after a pop
	endtask : pop
	// one-cycle strobe on the modem event or the identification read
	task automatic pulse(input logic modem);
		modem_change = modem;
		id_read = ~modem;
		@(negedge clk);
		modem_change = 1'b0;
		id_read = 1'b0;
		wait_clk(2);
	endtask : pulse
	task automatic wait_got(input int n);
		int k = 0;
		while (p.got_q.size() < n && k < 30000)
		begin
			@(negedge clk);
			k++;
		end
	endtask : wait_got

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin : main_seq
		logic [7:0] b;
		logic [7:0] tq[$];
		logic [7:0] rq[$];
		int n;
		int lows;
		wait_clk(5);
		rst_n = 1'b1;
		chk_bit("idle line", 1'b1, serial_out);
		chk_byte("id reset", fifo_serial_pkg::ID_RESET, interrupt_identification);
		chk_bit("full reset", 1'b0, tx_full);
		p.bit_cycles = bit_len(16'h0001, baud_source_select);
		// fill transmit side while fourteen frames arrive
		fork
			begin
				n = 0;
				while (tx_full !== 1'b1 && n < 20)
				begin
					b = 8'($random(seed));
					tq.push_back(b);
					push(b);
					n++;
				end
				chk_bit("depth", 1'b1, n >= 16 && n <= 17);
				push(8'h5a); // dropped while full
			end
			begin
				for (int i = 0; i < 14; i++)
				begin
					b = 8'($random(seed));
					rq.push_back(b);
					p.send_byte(b, 1'b0);
					wait_clk(20);
					if (i == 12)
						chk_byte("id below level", exp_id(3'h0, 1'b0), interrupt_identification);
				end
				chk_byte("id at level", exp_id(fifo_serial_pkg::SRC_RX_READY, 1'b1), interrupt_identification);
				chk_bit("irq ready", 1'b1, interrupt_request);
			end
		join
		wait_got(n);
		wait_clk(12 * p.bit_cycles);
		chk_byte("tx count", 8'(n), 8'(p.got_q.size()));
		foreach (tq[i])
			chk_byte("tx data", tq[i], p.got_q[i]);
		foreach (rq[i])
		begin
			pop(b);
			chk_byte("rx data", rq[i], b);
		end
		chk_bit("rx drained", 1'b0, rx_data_valid);
		// every frame format, both directions at once
		rx_trigger_select = 2'h0;
		for (int f = 0; f < 8; f++)
		begin
			p.got_q.delete();
			{parity_enable, parity_odd, two_stop} = 3'(f);
			{p.par_en, p.par_odd, p.two_stop} = 3'(f);
			divisor_low_byte = (f % 4 == 3) ? 8'h02 : 8'h01;
			p.bit_cycles = bit_len({divisor_high_byte, divisor_low_byte}, baud_source_select);
			b = 8'($random(seed));
			fork
				push(b);
				p.send_byte(~b, 1'b0);
			join
			wait_got(1);
			chk_byte("fmt tx", b, p.got_q[0]);
			tq[0] = ~b;
			pop(b);
			chk_byte("fmt rx", tq[0], b);
			wait_clk(3 * p.bit_cycles);
		end
		chk_byte("bad frames", 8'h00, 8'(p.bad_frames));
		// wrong parity from the far side
		interrupt_enable = 4'h5;
		p.send_byte(8'h3c, 1'b1);
		wait_clk(4);
		chk_bit("line err", 1'b1, rx_error);
		chk_byte("id line", exp_id(fifo_serial_pkg::SRC_LINE_STATUS, 1'b1), interrupt_identification);
		pulse(1'b0);
		chk_bit("err clear", 1'b0, rx_error);
		if (rx_data_valid === 1'b1)
			pop(b);
		// one waiting character, then silence
		interrupt_enable = 4'h1;
		rx_trigger_select = 2'h3;
		{parity_enable, parity_odd, two_stop} = 3'h0;
		{p.par_en, p.par_odd, p.two_stop} = 3'h0;
		divisor_low_byte = 8'h01;
		p.bit_cycles = bit_len(16'h0001, baud_source_select);
		p.send_byte(8'ha5, 1'b0);
		wait_clk(30 * p.bit_cycles);
		chk_byte("no early timeout", exp_id(3'h0, 1'b0), interrupt_identification);
		wait_clk(15 * p.bit_cycles);
		chk_byte("timeout", exp_id(fifo_serial_pkg::SRC_CHAR_TIMEOUT, 1'b1), interrupt_identification);
		pop(b);
		chk_byte("timeout data", 8'ha5, b);
		chk_byte("timeout gone", exp_id(3'h0, 1'b0), interrupt_identification);
		// transmit empty, then modem event with buffers off
		interrupt_enable = 4'h2;
		wait_clk(2);
		chk_byte("id tx empty", exp_id(fifo_serial_pkg::SRC_TX_EMPTY, 1'b1), interrupt_identification);
		tx_buffer_enable = 1'b0;
		rx_buffer_enable = 1'b0;
		interrupt_enable = 4'h8;
		pulse(1'b1);
		chk_byte("id modem", exp_id(fifo_serial_pkg::SRC_MODEM, 1'b1), interrupt_identification);
		chk_bit("irq modem", 1'b1, interrupt_request);
		pulse(1'b0);
		chk_bit("irq cleared", 1'b0, interrupt_request);
		// host side drives an internal loopback
		host_select = 1'b1;
		loopback = 1'b1;
		rx_trigger_select = 2'h0;
		p.got_q.delete();
		push(8'h96);
		lows = 0;
		repeat (12 * p.bit_cycles)
		begin
			@(negedge clk);
			if (serial_out !== 1'b1)
				lows++;
		end
		chk_bit("loop quiet", 1'b1, lows == 0 && p.got_q.size() == 0);
		pop(b);
		chk_byte("loop data", 8'h96, b);
		// link clock as baud source
		loopback = 1'b0;
		baud_source_select = fifo_serial_pkg::SRC_LINK;
		p.bit_cycles = bit_len(16'h0001, baud_source_select);
		fork
			push(8'hc3);
			p.send_byte(8'h3c, 1'b0);
		join
		wait_got(1);
		chk_byte("link tx", 8'hc3, p.got_q[0]);
		pop(b);
		chk_byte("link rx", 8'h3c, b);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
